/* serial_dac_load_control.sv */
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

module serial_dac_load_control #(
  parameter int unsigned RESOLUTION_BITS = 16,
  parameter int unsigned MONITOR_CYCLES  = dac_load_pkg::MONITOR_SETTLE
) (
  // system clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // serial link
  input  wire logic        serial_clk_in,
  input  wire logic        sync_n_in,
  input  wire logic        serial_in,
  input  wire logic        load_strobe_n_in,
  // static and control pins
  input  wire logic        coding_select_in,
  input  wire logic        output_clear_n_in,
  input  wire logic        ext_reset_in_n_in,
  input  wire logic        supply_good_in,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // analog stage controls
  output logic      [15:0] analog_out_code_out,
  output logic             output_clamp_out,
  output logic             monitor_reset_out_n
);

  // drop bits below the grade's resolution
  function automatic logic [15:0] resolve_word(input logic [15:0] word);
    logic [15:0] keep;
    keep = {16{1'b1}} << (dac_load_pkg::WORD_BITS - RESOLUTION_BITS);
    return word & keep;
  endfunction

  function automatic logic fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  // reset release
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rst_n = rst_s2_q;
  // link domain
  dac_load_pkg::link_word_type link_word;
  serial_word_shifter u_shifter (
    .link_clk_in   (serial_clk_in),
    .sync_n_in     (sync_n_in),
    .serial_in     (serial_in),
    .rst_n_in      (rst_n),
    .link_word_out (link_word)
  );

  // pin synchronisers
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_prev_q;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q   <= dac_load_pkg::PIN_RESET;
      pin_s2_q   <= dac_load_pkg::PIN_RESET;
      pin_prev_q <= dac_load_pkg::PIN_RESET;
    end else begin
      pin_s1_q   <= {supply_good_in, ext_reset_in_n_in, output_clear_n_in,
                     coding_select_in, load_strobe_n_in, sync_n_in};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  logic sync_fall;
  logic load_fall;
  logic coding_twos;
  logic clear_pin;
  logic reset_pin;
  logic supply_good;
  assign sync_fall   = fell(pin_prev_q[dac_load_pkg::PIN_SYNC_N],
                            pin_s2_q[dac_load_pkg::PIN_SYNC_N]);
  assign load_fall   = fell(pin_prev_q[dac_load_pkg::PIN_LOAD_N],
                            pin_s2_q[dac_load_pkg::PIN_LOAD_N]);
  assign coding_twos = pin_s2_q[dac_load_pkg::PIN_CODING];
  assign clear_pin   = ~pin_s2_q[dac_load_pkg::PIN_CLEAR_N];
  assign reset_pin   = ~pin_s2_q[dac_load_pkg::PIN_RESET_N];
  assign supply_good = pin_s2_q[dac_load_pkg::PIN_SUPPLY];

  // word completion crossing
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_prev_q;
  logic word_event;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1_q   <= 1'b0;
      tog_s2_q   <= 1'b0;
      tog_prev_q <= 1'b0;
    end else begin
      tog_s1_q   <= link_word.toggle;
      tog_s2_q   <= tog_s1_q;
      tog_prev_q <= tog_s2_q;
    end
  end

  assign word_event = tog_s2_q ^ tog_prev_q;

  // supply monitor qualification
  logic [7:0] settle_q;
  logic       monitor_ok_q;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      settle_q     <= 8'h00;
      monitor_ok_q <= 1'b0;
    end else if (!supply_good) begin
      settle_q     <= 8'h00;
      monitor_ok_q <= 1'b0;
    end else if (settle_q == 8'(MONITOR_CYCLES - 1)) begin
      monitor_ok_q <= 1'b1;
    end else begin
      settle_q <= settle_q + 8'h01;
    end
  end

  // register bus handshake
  logic wait_q;
  logic bus_req;
  logic bus_done;
  assign bus_req  = avs_read_in | avs_write_in;
  assign bus_done = bus_req & ~wait_q;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else if (bus_req && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // control register
  logic [1:0] ctrl_q;
  logic       soft_load_q;
  logic       ctrl_write;
  logic       status_write;
  assign ctrl_write   = bus_done && avs_write_in && avs_byteenable_in[0] &&
                        avs_address_in == dac_load_pkg::ADDR_CTRL;
  assign status_write = bus_done && avs_write_in && avs_byteenable_in[0] &&
                        avs_address_in == dac_load_pkg::ADDR_STATUS;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= dac_load_pkg::CTRL_RESET;
      soft_load_q <= 1'b0;
    end else if (ctrl_write) begin
      ctrl_q[dac_load_pkg::CTRL_UPDATE_EN]  <=
        avs_writedata_in[dac_load_pkg::CTRL_UPDATE_EN];
      ctrl_q[dac_load_pkg::CTRL_SOFT_CLEAR] <=
        avs_writedata_in[dac_load_pkg::CTRL_SOFT_CLEAR];
      soft_load_q <= avs_writedata_in[dac_load_pkg::CTRL_SOFT_LOAD];
    end else begin
      soft_load_q <= 1'b0;
    end
  end

  // update mode sampled as each frame opens
  logic auto_mode_q;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      auto_mode_q <= 1'b0;
    end else if (sync_fall) begin
      auto_mode_q <= ~pin_s2_q[dac_load_pkg::PIN_LOAD_N];
    end
  end
  // load decisions
  logic [15:0] input_word_q;
  logic        word_pending_q;
  logic        overrun_q;
  logic [15:0] frames_q;
  logic        clear_level;
  logic        reset_level;
  logic        auto_load;
  logic        held_load;
  logic        do_load;
  assign clear_level = clear_pin | ctrl_q[dac_load_pkg::CTRL_SOFT_CLEAR];
  assign reset_level = reset_pin | ~monitor_ok_q;
  assign auto_load   = word_event & auto_mode_q;
  assign held_load   = (load_fall | soft_load_q) & word_pending_q;
  assign do_load     = (auto_load | held_load) & ctrl_q[dac_load_pkg::CTRL_UPDATE_EN] &
                       ~clear_level & ~reset_level;
  // input register
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      input_word_q <= dac_load_pkg::CODE_ZERO;
      frames_q     <= dac_load_pkg::CODE_ZERO;
    end else if (word_event) begin
      input_word_q <= resolve_word(link_word.word);
      frames_q     <= frames_q + dac_load_pkg::FRAME_STEP;
    end
  end
  // a new word stays pending unless this very load consumes it
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      word_pending_q <= 1'b0;
    end else if (word_event && !(do_load && auto_load)) begin
      word_pending_q <= 1'b1;
    end else if (do_load) begin
      word_pending_q <= 1'b0;
    end
  end
  // new word over one never loaded; set wins over clear
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else if (word_event && word_pending_q && !held_load) begin
      overrun_q <= 1'b1;
    end else if (status_write && avs_writedata_in[dac_load_pkg::STAT_OVERRUN]) begin
      overrun_q <= 1'b0;
    end
  end
  // dac latch and output state
  logic [15:0]                 latch_q;
  dac_load_pkg::out_state_type state_q;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= dac_load_pkg::CLEAR_CODE;
    end else if (reset_level || clear_level) begin
      latch_q <= dac_load_pkg::CLEAR_CODE;
    end else if (do_load && auto_load) begin
      latch_q <= resolve_word(link_word.word);
    end else if (do_load) begin
      latch_q <= input_word_q;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dac_load_pkg::OUT_CLAMPED;
    end else begin
      case (state_q)
        dac_load_pkg::OUT_CLAMPED: begin
          if (do_load) begin
            state_q <= dac_load_pkg::OUT_ACTIVE;
          end
        end
        dac_load_pkg::OUT_ACTIVE, dac_load_pkg::OUT_CLEARED: begin
          if (reset_level) begin
            state_q <= dac_load_pkg::OUT_CLAMPED;
          end else if (clear_level) begin
            state_q <= dac_load_pkg::OUT_CLEARED;
          end else begin
            state_q <= dac_load_pkg::OUT_ACTIVE;
          end
        end
        default: begin
          state_q <= dac_load_pkg::OUT_CLAMPED;
        end
      endcase
    end
  end

  // analog stage drive
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      analog_out_code_out <= dac_load_pkg::CODE_ZERO;
      output_clamp_out    <= 1'b1;
      monitor_reset_out_n <= 1'b0;
    end else begin
      // twos complement flips the top bit so offset binary drives the stage
      analog_out_code_out <= coding_twos ? (latch_q ^ dac_load_pkg::MSB_FLIP)
                                         : latch_q;
      output_clamp_out    <= (state_q == dac_load_pkg::OUT_CLAMPED);
      monitor_reset_out_n <= monitor_ok_q;
    end
  end

  // status view and read data
  dac_load_pkg::status_type status;
  always_comb begin
    status              = '0;
    status.clamped      = (state_q == dac_load_pkg::OUT_CLAMPED);
    status.word_pending = word_pending_q;
    status.auto_mode    = auto_mode_q;
    status.monitor_ok   = monitor_ok_q;
    status.overrun      = overrun_q;
    status.clear_active = clear_level;
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_out <= 32'h00000000;
    end else if (bus_req && wait_q && avs_read_in) begin
      if (avs_address_in == dac_load_pkg::ADDR_CTRL) begin
        avs_readdata_out <= {30'h0, ctrl_q};
      end else if (avs_address_in == dac_load_pkg::ADDR_STATUS) begin
        avs_readdata_out <= status;
      end else if (avs_address_in == dac_load_pkg::ADDR_LATCH) begin
        avs_readdata_out <= {16'h0000, latch_q};
      end else if (avs_address_in == dac_load_pkg::ADDR_INPUT) begin
        avs_readdata_out <= {16'h0000, input_word_q};
      end else if (avs_address_in == dac_load_pkg::ADDR_FRAMES) begin
        avs_readdata_out <= {16'h0000, frames_q};
      end else begin
        avs_readdata_out <= 32'h00000000;
      end
    end
  end

  assign avs_waitrequest_out = wait_q;

endmodule

/* dac_load_pkg.sv */
package dac_load_pkg;

  // serial word format
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned COUNT_BITS  = 5;
  localparam logic [4:0]  WORD_COUNT  = 5'h10;
  localparam logic [4:0]  LAST_BIT    = 5'h0F;
  localparam logic [4:0]  COUNT_ZERO  = 5'h00;
  localparam logic [4:0]  COUNT_STEP  = 5'h01;

  // latch codes
  localparam logic [15:0] CLEAR_CODE  = 16'h0000;
  localparam logic [15:0] MSB_FLIP    = 16'h8000;
  localparam logic [15:0] CODE_ZERO   = 16'h0000;
  localparam logic [15:0] FRAME_STEP  = 16'h0001;

  // register byte addresses
  localparam logic [4:0]  ADDR_CTRL   = 5'h00;
  localparam logic [4:0]  ADDR_STATUS = 5'h04;
  localparam logic [4:0]  ADDR_LATCH  = 5'h08;
  localparam logic [4:0]  ADDR_INPUT  = 5'h0C;
  localparam logic [4:0]  ADDR_FRAMES = 5'h10;

  // control register fields
  localparam int unsigned CTRL_UPDATE_EN  = 0;
  localparam int unsigned CTRL_SOFT_CLEAR = 1;
  localparam int unsigned CTRL_SOFT_LOAD  = 2;
  localparam logic [1:0]  CTRL_RESET      = 2'h1;

  // status register write-one-to-clear field
  localparam int unsigned STAT_OVERRUN = 4;

  // pin synchroniser lanes
  localparam int unsigned PIN_LANES    = 6;
  localparam int unsigned PIN_SYNC_N   = 0;
  localparam int unsigned PIN_LOAD_N   = 1;
  localparam int unsigned PIN_CODING   = 2;
  localparam int unsigned PIN_CLEAR_N  = 3;
  localparam int unsigned PIN_RESET_N  = 4;
  localparam int unsigned PIN_SUPPLY   = 5;
  localparam logic [5:0]  PIN_RESET    = 6'h1B;

  // supply monitor settle count
  localparam int unsigned MONITOR_SETTLE = 8;

  typedef enum logic [1:0] {
    OUT_CLAMPED = 2'b00,
    OUT_ACTIVE  = 2'b01,
    OUT_CLEARED = 2'b10
  } out_state_type;

  typedef struct packed {
    logic        toggle;
    logic [15:0] word;
  } link_word_type;

  typedef struct packed {
    logic [25:0] zero;
    logic        clear_active;
    logic        overrun;
    logic        monitor_ok;
    logic        auto_mode;
    logic        word_pending;
    logic        clamped;
  } status_type;

endpackage

/* serial_word_shifter.sv */
`timescale 1ns/1ps

module serial_word_shifter (
  // link side
  input  wire logic                        link_clk_in,
  input  wire logic                        sync_n_in,
  input  wire logic                        serial_in,
  // reset from the system domain
  input  wire logic                        rst_n_in,
  // received word and completion toggle
  output dac_load_pkg::link_word_type      link_word_out
);

  logic [4:0]  bit_count_q;
  logic [15:0] shift_q;
  logic [15:0] word_q;
  logic        toggle_q;

  // frame gating: sync high holds the counter at zero
  always_ff @(negedge link_clk_in or negedge rst_n_in or posedge sync_n_in) begin
    if (!rst_n_in) begin
      bit_count_q <= dac_load_pkg::COUNT_ZERO;
    end else if (sync_n_in) begin
      bit_count_q <= dac_load_pkg::COUNT_ZERO;
    end else if (bit_count_q != dac_load_pkg::WORD_COUNT) begin
      bit_count_q <= bit_count_q + dac_load_pkg::COUNT_STEP;
    end
  end

  // msb first shift on falling serial clock
  always_ff @(negedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q <= dac_load_pkg::CODE_ZERO;
    end else if (!sync_n_in && bit_count_q != dac_load_pkg::WORD_COUNT) begin
      shift_q <= {shift_q[14:0], serial_in};
    end
  end

  // word capture on the sixteenth falling edge
  always_ff @(negedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_q   <= dac_load_pkg::CODE_ZERO;
      toggle_q <= 1'b0;
    end else if (!sync_n_in && bit_count_q == dac_load_pkg::LAST_BIT) begin
      word_q   <= {shift_q[14:0], serial_in};
      toggle_q <= ~toggle_q;
    end
  end

  assign link_word_out.toggle = toggle_q;
  assign link_word_out.word   = word_q;

endmodule

/* dac_load_checker_properties.sv */
`timescale 1ns/1ps

module dac_load_checker #(
  parameter int unsigned MONITOR_CYCLES = 8
) (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic        sync_n_in,
  input wire logic        load_strobe_n_in,
  input wire logic        coding_select_in,
  input wire logic        output_clear_n_in,
  input wire logic        ext_reset_in_n_in,
  input wire logic        supply_good_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [15:0] analog_out_code_out,
  input wire logic        output_clamp_out,
  input wire logic        monitor_reset_out_n
);
  logic [7:0] good_run_q;

  // cycles the supply monitor input has stayed high
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      good_run_q <= 8'h00;
    end else if (!supply_good_in) begin
      good_run_q <= 8'h00;
    end else if (good_run_q != 8'hFF) begin
      good_run_q <= good_run_q + 8'h01;
    end
  end

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus request not answered next cycle");
  chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low longer than one cycle");
  chk_wait_idle: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("waitrequest dropped without request");
  chk_read_upper: assert property (avs_read_in && !avs_waitrequest_out
    |-> avs_readdata_out[31:16] == 16'h0000) else $error("read data upper bits set");
  chk_unmapped_read: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in > 5'h10 |-> avs_readdata_out == 32'h00000000)
    else $error("unmapped read not zero");
  chk_clear_twos: assert property (
    (!output_clear_n_in && coding_select_in && ext_reset_in_n_in)[*8]
    |-> analog_out_code_out == 16'h8000) else $error("clear in twos complement not midscale");
  chk_clear_binary: assert property (
    (!output_clear_n_in && !coding_select_in && ext_reset_in_n_in)[*8]
    |-> analog_out_code_out == 16'h0000) else $error("clear in binary not zero code");
  chk_reset_clamp: assert property ((!ext_reset_in_n_in)[*5] |-> output_clamp_out)
    else $error("external reset did not clamp output");
  chk_monitor_low: assert property ((!supply_good_in)[*5] |-> !monitor_reset_out_n)
    else $error("monitor reset output not low");
  chk_monitor_rise: assert property ($rose(monitor_reset_out_n)
    |-> good_run_q >= 8'(MONITOR_CYCLES)) else $error("monitor reset released early");
  chk_idle_stable: assert property (
    (sync_n_in && load_strobe_n_in && output_clear_n_in && ext_reset_in_n_in
    && supply_good_in && !avs_write_in && $stable(coding_select_in))[*8]
    |-> $stable(analog_out_code_out)) else $error("output moved while deselected");
endmodule

bind serial_dac_load_control dac_load_checker #(.MONITOR_CYCLES(MONITOR_CYCLES))
  dac_load_checker_inst (.clock_in, .rst_n_in, .sync_n_in, .load_strobe_n_in,
  .coding_select_in, .output_clear_n_in, .ext_reset_in_n_in, .supply_good_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
  .avs_waitrequest_out, .analog_out_code_out, .output_clamp_out, .monitor_reset_out_n);

/* serial_host_model.sv */
`timescale 1ns/1ps

module serial_host_model (
  output logic serial_clk_out,
  output logic sync_n_out,
  output logic serial_data_out
);
  initial begin
    serial_clk_out  = 1'b1;
    sync_n_out      = 1'b1;
    serial_data_out = 1'b0;
  end

  // link clock runs only inside a transfer and idles high
  task automatic send(input logic [15:0] word, input int edges, input logic framed);
    #7 sync_n_out = ~framed;
    #200;
    for (int i = 0; i < edges; i++) begin
      serial_data_out = (i < 16) ? word[15 - i] : ~serial_data_out;
      #3 serial_clk_out = 1'b0;
      #3 serial_clk_out = 1'b1;
    end
    // released line shows no stale bit
    serial_data_out = ~serial_data_out;
    #100 sync_n_out = 1'b1;
    #200;
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
  logic        clock_in, rst_n_in, serial_clk_in, sync_n_in, serial_in;
  logic        load_strobe_n_in, coding_select_in, output_clear_n_in;
  logic        ext_reset_in_n_in, supply_good_in, avs_read_in, avs_write_in;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
  logic [3:0]  avs_byteenable_in;
  logic        avs_waitrequest_out, output_clamp_out, monitor_reset_out_n;
  logic [15:0] analog_out_code_out, word, held;
  int          fail_count, samples_checked, nframes;

  serial_dac_load_control #(.RESOLUTION_BITS(16), .MONITOR_CYCLES(2))
    serial_dac_load_control_inst (.clock_in, .rst_n_in, .serial_clk_in, .sync_n_in,
    .serial_in, .load_strobe_n_in, .coding_select_in, .output_clear_n_in,
    .ext_reset_in_n_in, .supply_good_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .analog_out_code_out, .output_clamp_out, .monitor_reset_out_n);

  serial_host_model host_inst (.serial_clk_out(serial_clk_in), .sync_n_out(sync_n_in),
    .serial_data_out(serial_in));

  function automatic logic [15:0] exp_code(input logic [15:0] w, input logic c);
    return c ? (w ^ 16'h8000) : w;
  endfunction

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
    int n;
    @(posedge clock_in);
    avs_address_in   <= addr;
    avs_writedata_in <= data;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      fail_count++;
      complete_run();
    end else begin
      rdata = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in  <= 1'b0;
    end
  endtask

  task automatic frame(input logic [15:0] w, input int edges, input logic framed);
    host_inst.send(w, edges, framed);
    repeat (8) @(posedge clock_in);
  endtask

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  initial begin
    #3000000;
    fail_count++;
    complete_run();
  end

  initial begin
    rst_n_in          = 1'b0;
    load_strobe_n_in  = 1'b1;
    coding_select_in  = 1'b0;
    output_clear_n_in = 1'b1;
    ext_reset_in_n_in = 1'b1;
    supply_good_in    = 1'b0;
    avs_address_in    = 5'h00;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_writedata_in  = 32'h0;
    avs_byteenable_in = 4'hF;
    void'($urandom(32'h92DD300F));
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    `CHECK(output_clamp_out, 1'b1)
    `CHECK(monitor_reset_out_n, 1'b0)
    bus(1'b0, dac_load_pkg::ADDR_CTRL, 32'h0);
    `CHECK(rdata, 32'h00000001)
    bus(1'b0, 5'h14, 32'h0);
    `CHECK(rdata, 32'h00000000)
    supply_good_in <= 1'b1;
    repeat (12) @(posedge clock_in);
    `CHECK(monitor_reset_out_n, 1'b1)
    load_strobe_n_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      word = (i == 0) ? 16'h8000 : (i == 1) ? 16'hFFFF : (i == 2) ? 16'h0000 : 16'($urandom);
      coding_select_in <= (i == 0) ? 1'b0 : 1'($urandom);
      frame(word, 16, 1'b1);
      nframes++;
      `CHECK(analog_out_code_out, exp_code(word, coding_select_in))
      `CHECK(output_clamp_out, 1'b0)
      bus(1'b0, dac_load_pkg::ADDR_LATCH, 32'h0);
      `CHECK(rdata, {16'h0000, word})
      bus(1'b0, dac_load_pkg::ADDR_FRAMES, 32'h0);
      `CHECK(rdata[15:0], nframes[15:0])
    end
    word = 16'($urandom);
    frame(word, 20, 1'b1);
    `CHECK(analog_out_code_out, exp_code(word, coding_select_in))
    frame(~word, 8, 1'b1);
    `CHECK(analog_out_code_out, exp_code(word, coding_select_in))
    word = word ^ 16'h00FF;
    frame(word, 16, 1'b1);
    `CHECK(analog_out_code_out, exp_code(word, coding_select_in))
    frame(~word, 16, 1'b0);
    `CHECK(analog_out_code_out, exp_code(word, coding_select_in))
    load_strobe_n_in <= 1'b1;
    held = word;
    word = 16'($urandom);
    frame(word, 16, 1'b1);
    `CHECK(analog_out_code_out, exp_code(held, coding_select_in))
    load_strobe_n_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHECK(analog_out_code_out, exp_code(word, coding_select_in))
    load_strobe_n_in <= 1'b1;
    held = 16'($urandom);
    frame(held, 16, 1'b1);
    bus(1'b0, dac_load_pkg::ADDR_STATUS, 32'h0);
    `CHECK(rdata, 32'h0000000A)
    bus(1'b0, dac_load_pkg::ADDR_INPUT, 32'h0);
    `CHECK(rdata, {16'h0000, held})
    bus(1'b1, dac_load_pkg::ADDR_CTRL, 32'h5);
    repeat (8) @(posedge clock_in);
    `CHECK(analog_out_code_out, exp_code(held, coding_select_in))
    load_strobe_n_in <= 1'b0;
    coding_select_in <= 1'b0;
    bus(1'b1, dac_load_pkg::ADDR_CTRL, 32'h3);
    repeat (8) @(posedge clock_in);
    `CHECK(analog_out_code_out, 16'h0000)
    bus(1'b1, dac_load_pkg::ADDR_CTRL, 32'h1);
    coding_select_in  <= 1'b1;
    output_clear_n_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHECK(analog_out_code_out, 16'h8000)
    coding_select_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHECK(analog_out_code_out, 16'h0000)
    output_clear_n_in <= 1'b1;
    ext_reset_in_n_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    `CHECK(output_clamp_out, 1'b1)
    frame(~word, 16, 1'b1);
    `CHECK(output_clamp_out, 1'b1)
    ext_reset_in_n_in <= 1'b1;
    frame(word, 16, 1'b1);
    `CHECK(output_clamp_out, 1'b0)
    `CHECK(analog_out_code_out, word)
    bus(1'b0, dac_load_pkg::ADDR_STATUS, 32'h0);
    `CHECK(rdata, 32'h0000001C)
    bus(1'b1, dac_load_pkg::ADDR_STATUS, 32'h10);
    bus(1'b0, dac_load_pkg::ADDR_STATUS, 32'h0);
    `CHECK(rdata, 32'h0000000C)
    supply_good_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    `CHECK(monitor_reset_out_n, 1'b0)
    `CHECK(output_clamp_out, 1'b1)
    complete_run();
  end
endmodule
